// ---- logic/spp_ports.sv ----
// Port D/E/F/G pin logic with pullups, peripheral sharing and an APB register slave.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module spp_ports (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spp_pkg::ADDR_W-1:0] paddr,
	input wire logic [spp_pkg::DATA_W-1:0] pwdata,
	output logic [spp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire spp_pkg::spp_periph_t periph,
	input wire logic [7:0] firstPortDirection,
	output logic [7:0] firstPortPullup,
	input wire logic [7:0] portEIn,
	output logic [7:0] portEOut,
	output logic [7:0] portEOe,
	input wire logic [7:0] portFIn,
	output logic [7:0] portFOut,
	output logic [7:0] portFOe,
	output logic [7:0] portFPullup,
	input wire logic [2:0] portGIn,
	output logic [2:0] portGOut,
	output logic [2:0] portGOe,
	input wire logic [2:0] keypadIrqEnableBits,
	output logic [2:0] keypadInputPin
);
	import spp_pkg::*;

	// ==========================================================
	// Helpers

	// Readback picks the latch for outputs and the pad for inputs.
	function automatic logic [7:0] pinRead(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] pad);
		pinRead = (latch & dir) | (pad & ~dir);
	endfunction : pinRead

	function automatic logic elsActive(input logic [1:0] els);
		elsActive = (els != ELS_GPIO);
	endfunction : elsActive

	// A write strobe needs the access cycle and a mapped index.
	function automatic logic writeTo(input logic taken, input logic [9:0] idx, input logic [9:0] target);
		writeTo = taken && (idx == target);
	endfunction : writeTo

	// ==========================================================
	// State
	logic [7:0] portEDataLatch_q;
	logic [7:0] portFDataLatch_q;
	logic [2:0] portGDataLatch_q;
	logic [7:0] portEDirection_q;
	logic [7:0] portFDirection_q;
	logic [2:0] portGDirection_q;
	logic [7:0] firstPortPullupEnables_q;
	logic [7:0] portFPullupEnables_q;
	spp_phase_t phase_q;
	logic [DATA_W-1:0] prdata_q;
	logic pslverr_q;
	logic [7:0] portEOut_q;
	logic [7:0] portEOe_q;
	logic [7:0] portFOut_q;
	logic [7:0] portFOe_q;
	logic [7:0] portFPullup_q;
	logic [7:0] firstPortPullup_q;
	logic [2:0] portGOut_q;
	logic [2:0] portGOe_q;
	logic [2:0] keypadInputPin_q;

	// ==========================================================
	// Bus decode
	logic [9:0] regIndex;
	logic setupCycle;
	logic writeTaken;
	logic [7:0] wByte;
	logic hit;
	logic [7:0] rByte;
	logic [7:0] portEOwned;
	logic [7:0] portFOwned;
	logic wrEData;
	logic wrFData;
	logic wrGData;
	logic wrEDir;
	logic wrFDir;
	logic wrGDir;
	logic wrDPue;
	logic wrFPue;

	assign regIndex = paddr[ADDR_W-1:2];
	assign setupCycle = psel && !penable && (phase_q == SPP_IDLE);
	assign writeTaken = psel && penable && pwrite && (phase_q == SPP_ANSWER) && !pslverr_q;
	assign wByte = pwdata[7:0];

	// One strobe per register keeps each register in a process of its own.
	assign wrEData = writeTo(writeTaken, regIndex, IDX_E_DATA);
	assign wrFData = writeTo(writeTaken, regIndex, IDX_F_DATA);
	assign wrGData = writeTo(writeTaken, regIndex, IDX_G_DATA);
	assign wrEDir = writeTo(writeTaken, regIndex, IDX_E_DIR);
	assign wrFDir = writeTo(writeTaken, regIndex, IDX_F_DIR);
	assign wrGDir = writeTo(writeTaken, regIndex, IDX_G_DIR);
	assign wrDPue = writeTo(writeTaken, regIndex, IDX_D_PUE);
	assign wrFPue = writeTo(writeTaken, regIndex, IDX_F_PUE);

	always_comb begin
		hit = 1'b1;
		rByte = 8'h00;
		case (regIndex)
			IDX_E_DATA: rByte = pinRead(portEDataLatch_q, portEDirection_q, portEIn);
			IDX_F_DATA: rByte = pinRead(portFDataLatch_q, portFDirection_q, portFIn);
			IDX_G_DATA: rByte = pinRead({5'h00, portGDataLatch_q}, {5'h00, portGDirection_q},
				{5'h00, portGIn});
			IDX_E_DIR: rByte = portEDirection_q;
			IDX_F_DIR: rByte = portFDirection_q;
			IDX_G_DIR: rByte = {5'h00, portGDirection_q};
			IDX_D_PUE: rByte = firstPortPullupEnables_q;
			IDX_F_PUE: rByte = portFPullupEnables_q;
			default: hit = 1'b0;
		endcase
	end

	// ==========================================================
	// APB handshake: one setup cycle, one access cycle with pready high.
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q <= SPP_IDLE;
		end else if (ce) begin
			case (phase_q)
				SPP_IDLE: begin
					if (setupCycle) begin
						phase_q <= SPP_ANSWER;
					end
				end
				SPP_ANSWER: begin
					phase_q <= SPP_IDLE;
				end
				default: begin
					phase_q <= SPP_IDLE;
				end
			endcase
		end
	end

	// Read data is taken at the setup edge, so the pads are those of that cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= '0;
		end else if (ce) begin
			if (setupCycle && !pwrite) begin
				prdata_q <= {{(DATA_W-8){1'b0}}, rByte};
			end else begin
				prdata_q <= '0;
			end
		end
	end

	// An unmapped index answers with an error and its write is dropped.
	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pslverr_q <= setupCycle && !hit;
		end
	end

	// ==========================================================
	// Data latches carry no reset.
	always_ff @(posedge clk) begin
		if (ce && wrEData) begin
			portEDataLatch_q <= wByte;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && wrFData) begin
			portFDataLatch_q <= wByte;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && wrGData) begin
			portGDataLatch_q <= wByte[2:0];
		end
	end

	// ==========================================================
	// Direction and pullup enable registers
	always_ff @(posedge clk) begin
		if (rst) begin
			portEDirection_q <= DIR_RESET;
		end else if (ce && wrEDir) begin
			portEDirection_q <= wByte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portFDirection_q <= DIR_RESET;
		end else if (ce && wrFDir) begin
			portFDirection_q <= wByte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portGDirection_q <= G_DIR_RESET;
		end else if (ce && wrGDir) begin
			portGDirection_q <= wByte[2:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			firstPortPullupEnables_q <= PUE_RESET;
		end else if (ce && wrDPue) begin
			firstPortPullupEnables_q <= wByte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portFPullupEnables_q <= PUE_RESET;
		end else if (ce && wrFPue) begin
			portFPullupEnables_q <= wByte;
		end
	end

	// ==========================================================
	// Pin ownership
	always_comb begin
		portEOwned = 8'h00;
		portEOwned[E_SCK] = periph.spiEnable;
		portEOwned[E_MOSI] = periph.spiEnable;
		portEOwned[E_MISO] = periph.spiEnable;
		portEOwned[E_SS] = periph.spiEnable && !periph.spiMaster;
		portEOwned[E_TA1] = elsActive(periph.timerAEls[1]);
		portEOwned[E_TA0] = elsActive(periph.timerAEls[0]);
		portEOwned[E_RXD] = periph.sciEnable;
		portEOwned[E_TXD] = periph.sciEnable;
		portFOwned = 8'h00;
		portFOwned[0] = elsActive(periph.timerAEls[2]);
		portFOwned[1] = elsActive(periph.timerAEls[3]);
		portFOwned[2] = elsActive(periph.timerBEls[2]);
		portFOwned[3] = elsActive(periph.timerBEls[3]);
		portFOwned[4] = elsActive(periph.timerBEls[0]);
		portFOwned[5] = elsActive(periph.timerBEls[1]);
	end

	// ==========================================================
	// Pad drive, registered so each pad output comes from a flop.
	// Drivers land one cycle after the controlling write or peripheral change.
	always_ff @(posedge clk) begin
		if (rst) begin
			portEOut_q <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < PORT_W; i++) begin
				if (portEOwned[i]) begin
					portEOut_q[i] <= periph.eOut[i];
				end else begin
					portEOut_q[i] <= portEDataLatch_q[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portEOe_q <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < PORT_W; i++) begin
				if (portEOwned[i]) begin
					portEOe_q[i] <= periph.eOe[i];
				end else begin
					portEOe_q[i] <= portEDirection_q[i];
				end
			end
			// Slave select and receive data are inputs whatever the peripheral asks.
			if (portEOwned[E_SS]) begin
				portEOe_q[E_SS] <= 1'b0;
			end
			if (portEOwned[E_RXD]) begin
				portEOe_q[E_RXD] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portFOut_q <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < PORT_W; i++) begin
				if (portFOwned[i] && i < 6) begin
					portFOut_q[i] <= periph.fOut[i % 6];
				end else begin
					portFOut_q[i] <= portFDataLatch_q[i];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portFOe_q <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < PORT_W; i++) begin
				if (portFOwned[i] && i < 6) begin
					portFOe_q[i] <= periph.fOe[i % 6];
				end else begin
					portFOe_q[i] <= portFDirection_q[i];
				end
			end
		end
	end

	// Pullups follow the direction bit alone, so an owned pin keeps its pullup choice.
	always_ff @(posedge clk) begin
		if (rst) begin
			firstPortPullup_q <= 8'h00;
		end else if (ce) begin
			firstPortPullup_q <= firstPortPullupEnables_q & ~firstPortDirection;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portFPullup_q <= 8'h00;
		end else if (ce) begin
			portFPullup_q <= portFPullupEnables_q & ~portFDirection_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portGOut_q <= 3'h0;
		end else if (ce) begin
			portGOut_q <= portGDataLatch_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			portGOe_q <= 3'h0;
		end else if (ce) begin
			portGOe_q <= portGDirection_q & ~keypadIrqEnableBits;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			keypadInputPin_q <= 3'h0;
		end else if (ce) begin
			keypadInputPin_q <= portGIn | ~keypadIrqEnableBits;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = phase_q[1];
	assign pslverr = pslverr_q;
	assign portEOut = portEOut_q;
	assign portEOe = portEOe_q;
	assign portFOut = portFOut_q;
	assign portFOe = portFOe_q;
	assign portFPullup = portFPullup_q;
	assign firstPortPullup = firstPortPullup_q;
	assign portGOut = portGOut_q;
	assign portGOe = portGOe_q;
	assign keypadInputPin = keypadInputPin_q;

endmodule : spp_ports

// ---- logic/spp_pkg.sv ----
// Constants, register map and carrier types for the shared pin port block.
package spp_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_E_DATA = 10'h008;
	localparam logic [9:0] IDX_F_DATA = 10'h009;
	localparam logic [9:0] IDX_G_DATA = 10'h00A;
	localparam logic [9:0] IDX_E_DIR = 10'h00C;
	localparam logic [9:0] IDX_F_DIR = 10'h00D;
	localparam logic [9:0] IDX_G_DIR = 10'h00E;
	localparam logic [9:0] IDX_D_PUE = 10'h010;
	localparam logic [9:0] IDX_F_PUE = 10'h011;

	// ==========================================================
	// Widths and reset values
	localparam int PORT_W = 8;
	localparam int G_W = 3;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [2:0] G_DIR_RESET = 3'h0;
	localparam logic [7:0] PUE_RESET = 8'h00;
	localparam logic [1:0] ELS_GPIO = 2'h0;

	// ==========================================================
	// Port E pin positions
	localparam int E_SCK = 7;
	localparam int E_MOSI = 6;
	localparam int E_MISO = 5;
	localparam int E_SS = 4;
	localparam int E_TA1 = 3;
	localparam int E_TA0 = 2;
	localparam int E_RXD = 1;
	localparam int E_TXD = 0;

	// ==========================================================
	// Bus phase, one-hot
	typedef enum logic [1:0] {
		SPP_IDLE = 2'b01,
		SPP_ANSWER = 2'b10
	} spp_phase_t;

	// Ownership and drive from the SPI, SCI and both timers.
	typedef struct packed {
		logic spiEnable;
		logic spiMaster;
		logic sciEnable;
		logic [3:0][1:0] timerAEls;
		logic [3:0][1:0] timerBEls;
		logic [7:0] eOut;
		logic [7:0] eOe;
		logic [5:0] fOut;
		logic [5:0] fOe;
	} spp_periph_t;

endpackage : spp_pkg

// ---- bench/spp_pad_model.sv ----
// Pad model for the far side: resolves driven, pulled and floating pin levels.
`timescale 1ns/10ps
module spp_pad_model #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pullEn,
	input wire logic [W-1:0] ext,
	input wire logic [W-1:0] extOe,
	output logic [W-1:0] pin
);
	// ====
	// Pin resolution
	// A floating pin flips every cycle, so a stale level is never mistaken for a driven one.
	logic [W-1:0] toggle_q = '0;
	always_ff @(posedge clk) begin
		toggle_q <= ~toggle_q;
	end
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin[i] = oe[i] ? out[i] : extOe[i] ? ext[i] : pullEn[i] ? 1'b1 : toggle_q[i];
		end
	end
endmodule : spp_pad_model

// ---- bench/spp_ports_chk.sv ----
// Concurrent checks on the shared pin port outputs.
`timescale 1ns/10ps
module spp_ports_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire spp_pkg::spp_periph_t periph,
	input wire logic [7:0] firstPortDirection,
	input wire logic [7:0] firstPortPullup,
	input wire logic [7:0] portEOut,
	input wire logic [7:0] portEOe,
	input wire logic [7:0] portFOe,
	input wire logic [2:0] portGOe,
	input wire logic [2:0] keypadIrqEnableBits
);
	import spp_pkg::*;
	// ====
	// Outputs are registered, so every cause is taken one edge back.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_pullup_gate: assert property ($past(ce) |-> (firstPortPullup & $past(firstPortDirection)) == 8'h00)
		else $error("pullup on an output pin");
	a_spi_owns: assert property (!$past(rst) && $past(periph.spiEnable) |-> portEOut[7:5] == $past(periph.eOut[7:5]))
		else $error("spi pins not driven by spi");
	a_ss_input: assert property (!$past(rst) && $past(periph.spiEnable && !periph.spiMaster) |-> !portEOe[4])
		else $error("slave select pin driven");
	a_sci_owns: assert property (!$past(rst) && $past(periph.sciEnable) |-> !portEOe[1] && portEOe[0] == $past(periph.eOe[0]))
		else $error("serial pins wrong");
	a_timer_pin: assert property (!$past(rst) && $past(periph.timerAEls[0] != ELS_GPIO) |-> portEOe[2] == $past(periph.eOe[2]))
		else $error("timer pin not owned");
	a_keypad_in: assert property ($past(ce) |-> (portGOe & $past(keypadIrqEnableBits)) == 3'h0)
		else $error("keypad pin driven");
	a_reset_dirs: assert property (disable iff (1'b0) rst |=> portEOe == 8'h00 && portFOe == 8'h00 && portGOe == 3'h0)
		else $error("pins driven after reset");
	a_ready_pulse: assert property (ce && psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	c_spi_slave: cover property (periph.spiEnable && !periph.spiMaster);
	c_keypad: cover property (keypadIrqEnableBits != 3'h0);
	c_pullup: cover property (firstPortPullup != 8'h00);
endmodule : spp_ports_chk

bind spp_ports spp_ports_chk u_chk (.clk, .rst, .ce, .psel, .penable, .pready, .periph, .firstPortDirection,
	.firstPortPullup, .portEOut, .portEOe, .portFOe, .portGOe, .keypadIrqEnableBits);

// ---- bench/spp_ports_tb.sv ----
// Self-checking bench for the shared pin port block.
`timescale 1ns/10ps
module spp_ports_tb;
	import spp_pkg::*;
	// ====
	// Stimulus, pads and result queue
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr;
	spp_periph_t periph = '0;
	logic [7:0] firstPortDirection = 8'h00;
	logic [7:0] firstPortPullup, portEIn, portEOut, portEOe, portFIn, portFOut, portFOe, portFPullup;
	logic [2:0] portGIn, portGOut, portGOe, keypadInputPin;
	logic [2:0] keypadIrqEnableBits = 3'h0;
	logic ce = 1'b1;
	logic [7:0] extE = 8'h3C;
	logic [7:0] extEOe = 8'hFF;
	logic [7:0] extF = 8'h00;
	logic [7:0] extFOe = 8'hFF;
	logic [2:0] extG = 3'h5;
	logic [2:0] extGOe = 3'h7;
	logic [7:0] rnd = 8'h11;
	logic [7:0] a, b;
	logic [2:0] g;
	logic [32:0] q[$];
	logic [32:0] e;
	int mismatches = 0;
	int n_checks = 0;
	spp_ports dut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.periph, .firstPortDirection, .firstPortPullup, .portEIn, .portEOut, .portEOe, .portFIn, .portFOut,
		.portFOe, .portFPullup, .portGIn, .portGOut, .portGOe, .keypadIrqEnableBits, .keypadInputPin);
	spp_pad_model #(.W(8)) padE (.clk, .out(portEOut), .oe(portEOe), .pullEn(8'h00), .ext(extE), .extOe(extEOe),
		.pin(portEIn));
	spp_pad_model #(.W(8)) padF (.clk, .out(portFOut), .oe(portFOe), .pullEn(portFPullup), .ext(extF),
		.extOe(extFOe), .pin(portFIn));
	spp_pad_model #(.W(3)) padG (.clk, .out(portGOut), .oe(portGOe), .pullEn(3'h0), .ext(extG), .extOe(extGOe),
		.pin(portGIn));
	initial begin
		forever #12.5 clk = ~clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk({25'h0, got}, {25'h0, exp});
	endtask : chk8
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask : settle
	// Holds the whole request until pready is seen high; upper data bits carry noise.
	// One idle edge follows each release, so the next call never re-drives a signal in the same step.
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [32:0] x);
		q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {rnd, rnd, rnd, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [7:0] v);
		settle();
		apb(1'b0, idx, 8'h00, {25'h0, v});
	endtask : rd
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			chk({pslverr, prdata}, e);
		end
	end
	initial begin
		repeat (4000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
	// ====
	// Scenarios
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(IDX_E_DIR, 8'h00);
		rd(IDX_F_DIR, 8'h00);
		rd(IDX_G_DIR, 8'h00);
		rd(IDX_D_PUE, 8'h00);
		apb(1'b0, 10'h3FF, 8'h00, {1'b1, 32'h0});
		$display("reset values done");
		rnd = lfsr(rnd);
		a = rnd;
		wr(IDX_E_DATA, a);
		wr(IDX_E_DIR, 8'hFF);
		rd(IDX_E_DATA, a);
		chk8(portEOe, 8'hFF);
		chk8(portEOut, a);
		wr(IDX_E_DIR, 8'h0F);
		rd(IDX_E_DATA, {extE[7:4], a[3:0]});
		$display("port e gpio done");
		periph.eOut <= ~a;
		periph.eOe <= 8'hFF;
		periph.spiEnable <= 1'b1;
		wr(IDX_E_DIR, 8'hFF);
		rd(IDX_E_DATA, a);
		chk8(portEOe & 8'h10, 8'h00);
		wr(IDX_E_DIR, 8'h00);
		rd(IDX_E_DATA, {~a[7:5], extE[4:0]});
		periph.spiMaster <= 1'b1;
		periph.sciEnable <= 1'b1;
		periph.timerAEls <= '1;
		periph.eOe <= 8'h00;
		wr(IDX_E_DIR, 8'hFF);
		settle();
		chk8(portEOe, 8'h10);
		chk8(portEOut & 8'h0D, ~a & 8'h0D);
		$display("port e sharing done");
		rnd = lfsr(rnd);
		b = rnd;
		wr(IDX_F_DATA, b);
		periph.timerBEls <= '1;
		periph.fOut <= ~b[5:0];
		periph.fOe <= 6'h15;
		wr(IDX_F_DIR, 8'hFF);
		rd(IDX_F_DATA, b);
		chk8(portFOut, {b[7:6], ~b[5:0]});
		chk8(portFOe, 8'hD5);
		periph <= '0;
		firstPortDirection <= 8'h0F;
		extFOe <= 8'h00;
		wr(IDX_D_PUE, 8'hFF);
		wr(IDX_F_PUE, 8'hA5);
		wr(IDX_F_DIR, 8'h0F);
		settle();
		chk8(firstPortPullup, 8'hF0);
		chk8(portFPullup, 8'hA0);
		wr(IDX_F_PUE, 8'hFF);
		rd(IDX_F_DATA, {4'hF, b[3:0]});
		$display("port f and pullups done");
		rnd = lfsr(rnd);
		g = rnd[2:0];
		wr(IDX_G_DATA, {5'h0, g});
		keypadIrqEnableBits <= 3'b101;
		wr(IDX_G_DIR, 8'h07);
		settle();
		chk8({5'h0, portGOe}, 8'h02);
		chk8({5'h0, keypadInputPin}, {5'h0, extG[2], 1'b1, extG[0]});
		chk8({5'h0, portGOut}, {5'h0, g});
		ce <= 1'b0;
		keypadIrqEnableBits <= 3'b000;
		settle();
		chk8({5'h0, portGOe}, 8'h02);
		ce <= 1'b1;
		settle();
		chk8({5'h0, portGOe}, 8'h07);
		$display("port g done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(IDX_F_PUE, 8'h00);
		wr(IDX_E_DIR, 8'hFF);
		wr(IDX_F_DIR, 8'hFF);
		wr(IDX_G_DIR, 8'h07);
		rd(IDX_E_DATA, a);
		rd(IDX_F_DATA, b);
		rd(IDX_G_DATA, {5'h0, g});
		$display("second reset done");
		tally_and_finish();
	end
endmodule : spp_ports_tb
